// File: csr_pkg.sv
package csr_pkg;

  // program counter width and data memory size
  localparam int PC_W = 12;
  localparam int DMEM_DEPTH = 256;
  localparam logic [csr_pkg::PC_W-1:0] PC_RESET = 12'h000;

  // bus map: word-aligned byte addresses
  localparam logic [1:0] DMEM_REGION = 2'h0;
  localparam logic [10:0] CMD_OFFSET = 11'h400;
  localparam logic [10:0] PCSTATE_OFFSET = 11'h404;
  localparam logic [10:0] RETADDR_OFFSET = 11'h408;

  // bank 0 locations of the special registers
  localparam logic [7:0] PORT_FIRST_ADDR = 8'h00;
  localparam logic [7:0] PTR_FIRST_ADDR = 8'h01;
  localparam logic [7:0] PORT_SECOND_ADDR = 8'h02;
  localparam logic [7:0] PTR_SECOND_ADDR = 8'h03;
  localparam logic [7:0] WORKREG_ADDR = 8'h05;
  localparam logic [7:0] PCLOW_ADDR = 8'h06;
  localparam logic [7:0] TPTR_LOW_ADDR = 8'h07;
  localparam logic [7:0] TRES_HIGH_ADDR = 8'h08;
  localparam logic [7:0] TPTR_HIGH_ADDR = 8'h09;
  localparam logic [7:0] FLAGS_ADDR = 8'h0a;

  // command word fields
  localparam int OP_LSB = 8;
  localparam int OP_MSB = 12;
  localparam int CMD_W = 13;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_ACK = 2'h3,
    ST_DUMMY = 2'h2
  } csr_state_e;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_MOV_A_M = 5'h01,
    OP_MOV_M_A = 5'h02,
    OP_ADD = 5'h03,
    OP_SUB = 5'h04,
    OP_AND = 5'h05,
    OP_OR = 5'h06,
    OP_XOR = 5'h07,
    OP_INC_M = 5'h08,
    OP_DEC_M = 5'h09,
    OP_RLC_M = 5'h0a,
    OP_CLR_M = 5'h0b,
    OP_TABRD_M = 5'h0c,
    OP_MOV_A_IMM = 5'h0d,
    OP_HALT = 5'h0e,
    OP_WATCHDOG_CLEAR = 5'h0f,
    OP_CALL = 5'h10,
    OP_RET = 5'h11
  } csr_op_e;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic powerdown_flag;
    logic sign_wrap_flag;
    logic zero_flag;
    logic half_spill_flag;
    logic carry_flag;
  } csr_flags_s;

endpackage

// File: csr_core.sv
// What this block does
// - indirect ports hold nothing; accesses go where their pointer names
// - first pointer reaches bank 0 only; second pointer reaches every bank
// - indirect port read gives 00h; writing a port that way does nothing
// - direct addresses reach bank 0 only; other banks need pointer two
// - pointers are 8-bit memory bytes; read, write, increment, decrement
// - two-operand alu results land in the working register; no memory to memory move
// - writing the low program counter byte jumps within the current page
// - a write to the low program counter byte adds one dummy cycle
// - table read fetches pointed word; high byte kept, low to destination
// - flag writes change arithmetic flags, never the two system flags
// - carry set on add carry or no subtract borrow; rotate sets it too
// - half spill set on low nibble carry, or no nibble borrow on subtract
// - zero flag follows whether an add, subtract, and, or, xor, increment or decrement result is zero
// - sign wrap set when carry into top bit differs from carry out
// - powerdown flag cleared by reset or watchdog clear, set by halt only
// - expiry flag cleared by reset, watchdog clear, halt; set by timeout
// - calls save only the return address, never the flags
// - flag bits 7 to 6 read zero; low four writable; system flags reset 0
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
module csr_core (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [10:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic [15:0] TABLE_DATA,
  output logic [15:0] TABLE_ADDRESS,
  output logic [csr_pkg::PC_W-1:0] PROG_COUNTER,
  output csr_pkg::csr_flags_s CORE_FLAGS,
  output logic DUMMY_CYCLE
);

  csr_pkg::csr_state_e state;
  csr_pkg::csr_state_e next_state;
  csr_pkg::csr_op_e op;
  csr_pkg::csr_flags_s flags;
  csr_pkg::csr_flags_s next_flags;

  logic [7:0] dmem [0:csr_pkg::DMEM_DEPTH-1];
  logic [7:0] working_register;
  logic [7:0] table_pointer_low;
  logic [7:0] table_pointer_high;
  logic [7:0] table_result_high;
  logic [csr_pkg::PC_W-1:0] pc;
  logic [csr_pkg::PC_W-1:0] ret_addr;
  logic [csr_pkg::CMD_W-1:0] last_cmd;
  logic [7:0] sfr_value;
  logic [7:0] alu_result;
  logic acc_dest;
  logic mem_dest;
  logic [31:0] read_word;

  function automatic logic is_port(input logic [7:0] a);
    is_port = (a == csr_pkg::PORT_FIRST_ADDR) ||
              (a == csr_pkg::PORT_SECOND_ADDR);
  endfunction

  function automatic logic is_flop_reg(input logic [7:0] a);
    is_flop_reg = (a == csr_pkg::WORKREG_ADDR) ||
                  (a == csr_pkg::PCLOW_ADDR) ||
                  (a == csr_pkg::TPTR_LOW_ADDR) ||
                  (a == csr_pkg::TRES_HIGH_ADDR) ||
                  (a == csr_pkg::TPTR_HIGH_ADDR) ||
                  (a == csr_pkg::FLAGS_ADDR);
  endfunction

  // request decode; the master holds the request until acknowledged
  wire exec = state == csr_pkg::ST_EXEC;
  wire in_dmem = AVS_ADDRESS[10:9] == csr_pkg::DMEM_REGION;
  wire is_cmd_addr = AVS_ADDRESS == csr_pkg::CMD_OFFSET;
  wire cmd_lanes = AVS_BYTEENABLE[1:0] == 2'h3;
  wire cmd_go = exec && AVS_WRITE && is_cmd_addr && cmd_lanes;
  wire dwr_go = exec && AVS_WRITE && in_dmem && AVS_BYTEENABLE[0];
  wire [4:0] op_code = AVS_WRITEDATA[csr_pkg::OP_MSB:csr_pkg::OP_LSB];

  assign op = cmd_go ? csr_pkg::csr_op_e'(op_code) : csr_pkg::OP_NOP;

  // direct addresses carry no bank bit, so they stay in bank 0
  wire [6:0] direct_low = cmd_go ? AVS_WRITEDATA[6:0] : AVS_ADDRESS[8:2];
  wire [7:0] direct_addr = {1'b0, direct_low};

  // pointers live in the data memory array itself
  wire [7:0] ptr_first = dmem[csr_pkg::PTR_FIRST_ADDR];
  wire [7:0] ptr_second = dmem[csr_pkg::PTR_SECOND_ADDR];
  wire via_port = is_port(direct_addr);
  wire via_first = direct_addr == csr_pkg::PORT_FIRST_ADDR;

  // first pointer loses its bank bit, second keeps all eight
  wire [7:0] first_target = {1'b0, ptr_first[6:0]};
  wire [7:0] port_target = via_first ? first_target : ptr_second;
  wire [7:0] eff_addr = via_port ? port_target : direct_addr;

  // a pointer aimed back at a port finds no storage
  wire eff_null = via_port && is_port(eff_addr);

  always_comb begin
    sfr_value = dmem[eff_addr];
    if (eff_addr == csr_pkg::WORKREG_ADDR) begin
      sfr_value = working_register;
    end else if (eff_addr == csr_pkg::PCLOW_ADDR) begin
      sfr_value = pc[7:0];
    end else if (eff_addr == csr_pkg::TPTR_LOW_ADDR) begin
      sfr_value = table_pointer_low;
    end else if (eff_addr == csr_pkg::TRES_HIGH_ADDR) begin
      sfr_value = table_result_high;
    end else if (eff_addr == csr_pkg::TPTR_HIGH_ADDR) begin
      sfr_value = table_pointer_high;
    end else if (eff_addr == csr_pkg::FLAGS_ADDR) begin
      sfr_value = {2'h0, flags};
    end
  end

  wire [7:0] operand = eff_null ? 8'h00 : sfr_value;

  // one adder serves both add and subtract; subtract adds the inverse
  wire sub_op = op == csr_pkg::OP_SUB;
  wire [7:0] addend = sub_op ? ~operand : operand;
  wire [8:0] sum9 = {1'b0, working_register} + {1'b0, addend} +
                    {8'h00, sub_op};
  wire [4:0] half5 = {1'b0, working_register[3:0]} + {1'b0, addend[3:0]} +
                     {4'h0, sub_op};
  wire carry_in7 = sum9[7] ^ working_register[7] ^ addend[7];
  wire [7:0] inc_val = operand + 8'h01;
  wire [7:0] dec_val = operand - 8'h01;
  wire [7:0] rot_val = {operand[6:0], flags.carry_flag};

  // every result goes either to the working register or to one location
  always_comb begin
    alu_result = 8'h00;
    acc_dest = 1'b0;
    mem_dest = 1'b0;
    case (op)
      csr_pkg::OP_MOV_A_M: begin
        alu_result = operand;
        acc_dest = 1'b1;
      end
      csr_pkg::OP_MOV_M_A: begin
        alu_result = working_register;
        mem_dest = 1'b1;
      end
      csr_pkg::OP_ADD, csr_pkg::OP_SUB: begin
        alu_result = sum9[7:0];
        acc_dest = 1'b1;
      end
      csr_pkg::OP_AND: begin
        alu_result = working_register & operand;
        acc_dest = 1'b1;
      end
      csr_pkg::OP_OR: begin
        alu_result = working_register | operand;
        acc_dest = 1'b1;
      end
      csr_pkg::OP_XOR: begin
        alu_result = working_register ^ operand;
        acc_dest = 1'b1;
      end
      csr_pkg::OP_INC_M: begin
        alu_result = inc_val;
        mem_dest = 1'b1;
      end
      csr_pkg::OP_DEC_M: begin
        alu_result = dec_val;
        mem_dest = 1'b1;
      end
      csr_pkg::OP_RLC_M: begin
        alu_result = rot_val;
        mem_dest = 1'b1;
      end
      csr_pkg::OP_CLR_M: begin
        alu_result = 8'h00;
        mem_dest = 1'b1;
      end
      csr_pkg::OP_TABRD_M: begin
        alu_result = TABLE_DATA[7:0];
        mem_dest = 1'b1;
      end
      csr_pkg::OP_MOV_A_IMM: begin
        alu_result = AVS_WRITEDATA[7:0];
        acc_dest = 1'b1;
      end
      default: begin
        alu_result = 8'h00;
      end
    endcase
  end

  wire mem_wr = dwr_go || mem_dest;
  wire [7:0] mem_wdata = dwr_go ? AVS_WRITEDATA[7:0] : alu_result;
  wire mem_hit = mem_wr && !eff_null;
  wire arr_we = mem_hit && !is_flop_reg(eff_addr);
  wire wr_workreg = mem_hit && (eff_addr == csr_pkg::WORKREG_ADDR);
  wire wr_tptr_low = mem_hit && (eff_addr == csr_pkg::TPTR_LOW_ADDR);
  wire wr_tptr_high = mem_hit && (eff_addr == csr_pkg::TPTR_HIGH_ADDR);
  wire wr_tres_high = mem_hit && (eff_addr == csr_pkg::TRES_HIGH_ADDR);
  wire wr_flags = mem_hit && (eff_addr == csr_pkg::FLAGS_ADDR);
  wire jump_low = mem_hit && (eff_addr == csr_pkg::PCLOW_ADDR);
  wire tabrd = op == csr_pkg::OP_TABRD_M;
  wire call_op = op == csr_pkg::OP_CALL;
  wire ret_op = op == csr_pkg::OP_RET;

  // op flags are applied after a write to the flag location, so they win
  always_comb begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags.sign_wrap_flag = mem_wdata[3];
      next_flags.zero_flag = mem_wdata[2];
      next_flags.half_spill_flag = mem_wdata[1];
      next_flags.carry_flag = mem_wdata[0];
    end
    case (op)
      csr_pkg::OP_ADD, csr_pkg::OP_SUB: begin
        next_flags.carry_flag = sum9[8];
        next_flags.half_spill_flag = half5[4];
        next_flags.zero_flag = sum9[7:0] == 8'h00;
        next_flags.sign_wrap_flag = carry_in7 ^ sum9[8];
      end
      csr_pkg::OP_AND, csr_pkg::OP_OR, csr_pkg::OP_XOR,
      csr_pkg::OP_INC_M, csr_pkg::OP_DEC_M: begin
        next_flags.zero_flag = alu_result == 8'h00;
      end
      csr_pkg::OP_RLC_M: begin
        next_flags.carry_flag = operand[7];
      end
      csr_pkg::OP_HALT: begin
        next_flags.powerdown_flag = 1'b1;
        next_flags.watchdog_expiry_flag = 1'b0;
      end
      csr_pkg::OP_WATCHDOG_CLEAR: begin
        next_flags.powerdown_flag = 1'b0;
        next_flags.watchdog_expiry_flag = 1'b0;
      end
      default: begin
        next_flags.carry_flag = next_flags.carry_flag;
      end
    endcase
    // a timeout in the same cycle as a clear is not lost
    if (WATCHDOG_TIMEOUT) begin
      next_flags.watchdog_expiry_flag = 1'b1;
    end
  end

  // jumps keep the page bits; a call stores only the return address
  wire [csr_pkg::PC_W-1:0] pc_plus = pc + csr_pkg::PC_W'(1);
  wire [csr_pkg::PC_W-1:0] pc_jump = {pc[csr_pkg::PC_W-1:8], mem_wdata};
  wire [csr_pkg::PC_W-1:0] pc_call = {pc[csr_pkg::PC_W-1:8],
                                      AVS_WRITEDATA[7:0]};
  wire [csr_pkg::PC_W-1:0] next_pc = jump_low ? pc_jump :
                                     call_op ? pc_call :
                                     ret_op ? ret_addr :
                                     cmd_go ? pc_plus : pc;
  wire [csr_pkg::PC_W-1:0] next_ret = call_op ? pc_plus : ret_addr;
  wire [7:0] next_workreg = acc_dest ? alu_result :
                            wr_workreg ? mem_wdata : working_register;
  wire [7:0] next_tres_high = tabrd ? TABLE_DATA[15:8] :
                              wr_tres_high ? mem_wdata : table_result_high;
  wire [7:0] next_tptr_low = wr_tptr_low ? mem_wdata : table_pointer_low;
  wire [7:0] next_tptr_high = wr_tptr_high ? mem_wdata : table_pointer_high;
  wire [csr_pkg::CMD_W-1:0] next_cmd =
    cmd_go ? AVS_WRITEDATA[csr_pkg::CMD_W-1:0] : last_cmd;

  always_comb begin
    read_word = 32'h0000_0000;
    if (in_dmem) begin
      read_word = {24'h00_0000, operand};
    end else if (AVS_ADDRESS == csr_pkg::CMD_OFFSET) begin
      read_word = {{(32 - csr_pkg::CMD_W){1'b0}}, last_cmd};
    end else if (AVS_ADDRESS == csr_pkg::PCSTATE_OFFSET) begin
      read_word = {{(32 - csr_pkg::PC_W){1'b0}}, pc};
    end else if (AVS_ADDRESS == csr_pkg::RETADDR_OFFSET) begin
      read_word = {{(32 - csr_pkg::PC_W){1'b0}}, ret_addr};
    end
  end

  always_comb begin
    next_state = csr_pkg::ST_IDLE;
    case (state)
      csr_pkg::ST_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          next_state = csr_pkg::ST_EXEC;
        end
      end
      csr_pkg::ST_EXEC: begin
        next_state = jump_low ? csr_pkg::ST_DUMMY :
                                csr_pkg::ST_ACK;
      end
      csr_pkg::ST_DUMMY: begin
        next_state = csr_pkg::ST_ACK;
      end
      default: begin
        next_state = csr_pkg::ST_IDLE;
      end
    endcase
  end

  wire [31:0] next_readdata = (exec && AVS_READ) ? read_word : AVS_READDATA;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      for (int i = 0; i < csr_pkg::DMEM_DEPTH; i++) begin
        dmem[i] <= csr_pkg::BYTE_RESET;
      end
    end else if (arr_we) begin
      dmem[eff_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state <= csr_pkg::ST_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
      DUMMY_CYCLE <= 1'b0;
    end else begin
      state <= next_state;
      AVS_WAITREQUEST <= next_state != csr_pkg::ST_ACK;
      AVS_READDATA <= next_readdata;
      DUMMY_CYCLE <= next_state == csr_pkg::ST_DUMMY;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      flags <= csr_pkg::FLAGS_RESET;
      pc <= csr_pkg::PC_RESET;
      ret_addr <= csr_pkg::PC_RESET;
      last_cmd <= '0;
    end else begin
      flags <= next_flags;
      pc <= next_pc;
      ret_addr <= next_ret;
      last_cmd <= next_cmd;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      working_register <= csr_pkg::BYTE_RESET;
      table_pointer_low <= csr_pkg::BYTE_RESET;
      table_pointer_high <= csr_pkg::BYTE_RESET;
      table_result_high <= csr_pkg::BYTE_RESET;
    end else begin
      working_register <= next_workreg;
      table_pointer_low <= next_tptr_low;
      table_pointer_high <= next_tptr_high;
      table_result_high <= next_tres_high;
    end
  end

  // program memory is expected to answer combinationally on this address
  assign TABLE_ADDRESS = {table_pointer_high, table_pointer_low};
  assign PROG_COUNTER = pc;
  assign CORE_FLAGS = flags;

endmodule

// File: csr_core_chk.sv
module csr_core_chk (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [10:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic [15:0] TABLE_DATA,
  input wire logic [15:0] TABLE_ADDRESS,
  input wire logic [csr_pkg::PC_W-1:0] PROG_COUNTER,
  input wire csr_pkg::csr_flags_s CORE_FLAGS,
  input wire logic DUMMY_CYCLE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  // state may only move in an ack cycle or the dummy cycle of a jump
  wire wr_done = AVS_WRITE && (!AVS_WAITREQUEST || DUMMY_CYCLE);
  wire cmd_done = wr_done && AVS_ADDRESS == csr_pkg::CMD_OFFSET;
  wire [3:0] arith = CORE_FLAGS[3:0];
  wire [3:0] pc_page = PROG_COUNTER[11:8];
  sequence pcl_req;
    $rose(AVS_WRITE) && AVS_ADDRESS == 11'h018 && AVS_BYTEENABLE[0];
  endsequence
  sequence dummy_then_ack;
    DUMMY_CYCLE ##1 (!AVS_WAITREQUEST && !DUMMY_CYCLE);
  endsequence
  sequence req_up;
    $rose(AVS_READ || AVS_WRITE);
  endsequence
  pcl_dummy_a: assert property (pcl_req |-> ##2 dummy_then_ack)
    else $error("no single dummy cycle after a low pc write");
  pcl_jump_a: assert property (DUMMY_CYCLE |->
    pc_page == $past(pc_page)
    && (AVS_ADDRESS != 11'h018 || PROG_COUNTER[7:0] == AVS_WRITEDATA[7:0]))
    else $error("jump left the page or took the wrong low byte");
  flag_read_a: assert property (!AVS_WAITREQUEST && AVS_READ
    && AVS_ADDRESS == 11'h028 |-> AVS_READDATA[7:0] == {2'b00, CORE_FLAGS})
    else $error("flag byte read does not match the flags");
  pdown_stable_a: assert property (
    $changed(CORE_FLAGS.powerdown_flag) |-> cmd_done)
    else $error("powerdown flag moved without a command");
  wdog_set_a: assert property (WATCHDOG_TIMEOUT |=>
    CORE_FLAGS.watchdog_expiry_flag)
    else $error("timeout did not set the expiry flag");
  wdog_clear_a: assert property (
    $fell(CORE_FLAGS.watchdog_expiry_flag) |-> cmd_done)
    else $error("expiry flag cleared without a command");
  arith_hold_a: assert property ($changed(arith) |-> wr_done)
    else $error("arithmetic flags moved with no write");
  tptr_hold_a: assert property ($changed(TABLE_ADDRESS) |-> wr_done)
    else $error("table address moved with no write");
  call_flags_a: assert property (cmd_done
    && AVS_WRITEDATA[12:8] == csr_pkg::OP_CALL |-> $stable(CORE_FLAGS))
    else $error("call changed the flags");
  bus_answer_a: assert property (req_up |->
    AVS_WAITREQUEST [*2] ##[1:2] !AVS_WAITREQUEST)
    else $error("bus answer outside its latency");
endmodule

// File: test_core_special_registers.sv
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end

module test_core_special_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [10:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata, got, x;
  logic waitreq, dummy;
  logic wdt = 1'b0;
  logic [3:0] be = 4'hf;
  logic [15:0] tdata, taddr;
  logic [11:0] pc, ret;
  csr_pkg::csr_flags_s flags, fsave;
  logic [7:0] a, m;
  logic [3:0] f;
  logic [11:0] e;
  logic [4:0] ops[6] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0a};
  logic [7:0] ca[4] = '{8'h7f, 8'h00, 8'hf0, 8'h00};
  logic [7:0] cm[4] = '{8'h01, 8'h01, 8'h0f, 8'h00};
  logic [31:0] seed = 32'hf7538741;
  int miscompares = 0;
  int num_checks = 0;
  int dummies = 0;
  int n;
  always #12.5 clk = ~clk;
  // program memory stand-in: a fixed scramble of the table address
  assign tdata = {taddr[15:8] + 8'h3c, taddr[7:0] ^ 8'ha5};
  always @(posedge clk) if (dummy === 1'b1) dummies++;
  csr_core u_csr_core (.SYS_CLK(clk), .RESET(reset), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .WATCHDOG_TIMEOUT(wdt), .TABLE_DATA(tdata), .TABLE_ADDRESS(taddr),
    .PROG_COUNTER(pc), .CORE_FLAGS(flags), .DUMMY_CYCLE(dummy));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // result in [7:0], arithmetic flags in [11:8]
  function automatic logic [11:0] alu(input logic [4:0] op,
    input logic [7:0] a, input logic [7:0] m, input logic [3:0] f);
    logic [7:0] b, t;
    logic [8:0] s;
    logic [4:0] h;
    logic ci;
    ci = (op == 5'h04);
    b = ci ? ~m : m;
    s = {1'b0, a} + {1'b0, b} + ci;
    h = {1'b0, a[3:0]} + b[3:0] + ci;
    t = {1'b0, a[6:0]} + b[6:0] + ci;
    case (op)
      5'h03, 5'h04: return {t[7] ^ s[8], s[7:0] == 0, h[4], s[8], s[7:0]};
      5'h05: return {f[3], (a & m) == 0, f[1:0], a & m};
      5'h06: return {f[3], (a | m) == 0, f[1:0], a | m};
      5'h07: return {f[3], (a ^ m) == 0, f[1:0], a ^ m};
      default: return {f[3:1], m[7], m[6:0], f[0]};
    endcase
  endfunction

  task automatic bus(input logic w, input logic [10:0] ad,
    input logic [31:0] d);
    int k;
    k = 0;
    adr <= ad;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    while (waitreq !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k == 20) miscompares++;
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wm(input logic [7:0] loc, input logic [7:0] v);
    bus(1'b1, {1'b0, loc, 2'b00}, {24'h0, v});
  endtask

  task automatic rm(input logic [7:0] loc);
    bus(1'b0, {1'b0, loc, 2'b00}, 32'h0);
  endtask

  task automatic cmd(input logic [4:0] op, input logic [7:0] opr);
    bus(1'b1, csr_pkg::CMD_OFFSET, {19'h0, op, opr});
  endtask

  task automatic pulse_wdt();
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK("reset flags", 6'h00, flags)
    x = rnd();
    wm(8'h01, 8'hc0);
    wm(8'h00, x[7:0]);
    rm(8'h40); `CHK("bank0 via first", x[7:0], got[7:0])
    wm(8'h03, 8'hc0);
    wm(8'h02, ~x[7:0]);
    rm(8'h02); `CHK("bank1 via second", ~x[7:0], got[7:0])
    rm(8'h40); `CHK("bank0 untouched", x[7:0], got[7:0])
    cmd(5'h08, 8'h03);
    cmd(5'h08, 8'h03);
    cmd(5'h09, 8'h03);
    rm(8'h03); `CHK("pointer step", 8'hc1, got[7:0])
    wm(8'h03, 8'h00);
    rm(8'h02); `CHK("port reads zero", 8'h00, got[7:0])
    wm(8'h02, 8'h5a);
    rm(8'h40); `CHK("port write void", x[7:0], got[7:0])
    wm(8'h21, x[23:16]);
    cmd(5'h01, 8'h21);
    cmd(5'h02, 8'h22);
    rm(8'h22); `CHK("move via work", x[23:16], got[7:0])
    wm(8'h03, 8'h22);
    cmd(5'h0b, 8'h02);
    rm(8'h22); `CHK("clear via port", 8'h00, got[7:0])
    be <= 4'he;
    wm(8'h22, 8'h77);
    be <= 4'hf;
    rm(8'h22); `CHK("lane refused", 8'h00, got[7:0])
    cmd(5'h0d, x[31:24]);
    rm(8'h05); `CHK("immediate", x[31:24], got[7:0])
    wm(8'h0a, 8'h00);
    f = 4'h0;
    for (int i = 0; i < 48; i++) begin
      x = rnd();
      a = (i < 4) ? ca[i] : x[7:0];
      m = (i < 4) ? cm[i] : x[15:8];
      wm(8'h05, a);
      wm(8'h20, m);
      cmd(ops[i % 6], 8'h20);
      e = alu(ops[i % 6], a, m, f);
      rm((i % 6 == 5) ? 8'h20 : 8'h05);
      `CHK("alu result", e[7:0], got[7:0])
      `CHK("alu flags", e[11:8], flags[3:0])
      f = e[11:8];
    end
    wm(8'h0a, 8'hff); `CHK("flag write", 2'b00, flags[5:4])
    rm(8'h0a); `CHK("flag byte", 8'h0f, got[7:0])
    cmd(csr_pkg::OP_HALT, 8'h00); `CHK("halt", 2'b01, flags[5:4])
    pulse_wdt(); `CHK("timeout", 2'b11, flags[5:4])
    wm(8'h0a, 8'h00); `CHK("flag write keep", 6'h30, flags)
    cmd(csr_pkg::OP_WATCHDOG_CLEAR, 8'h00);
    `CHK("wd clear", 2'b00, flags[5:4])
    pulse_wdt();
    cmd(csr_pkg::OP_HALT, 8'h00);
    `CHK("halt clears", 2'b01, flags[5:4])
    wm(8'h06, 8'hfe);
    repeat (3) cmd(csr_pkg::OP_NOP, 8'h00);
    `CHK("pc carry", 12'h101, pc)
    n = dummies;
    x = rnd();
    wm(8'h06, x[7:0]); `CHK("pc page", {4'h1, x[7:0]}, pc)
    `CHK("dummy count", n + 1, dummies)
    ret = pc + 12'h001;
    wm(8'h0a, x[11:8]);
    fsave = flags;
    cmd(csr_pkg::OP_CALL, 8'h40); `CHK("call pc", 8'h40, pc[7:0])
    bus(1'b0, csr_pkg::RETADDR_OFFSET, 32'h0);
    `CHK("ret addr", ret, got[11:0])
    cmd(csr_pkg::OP_RET, 8'h00); `CHK("ret pc", ret, pc)
    `CHK("flags kept", fsave, flags)
    bus(1'b0, csr_pkg::PCSTATE_OFFSET, 32'h0);
    `CHK("pc read", ret, got[11:0])
    bus(1'b0, csr_pkg::CMD_OFFSET, 32'h0);
    `CHK("cmd read", 32'h0000_1100, got)
    x = rnd();
    wm(8'h07, x[7:0]);
    wm(8'h09, x[15:8]); `CHK("table addr", x[15:0], taddr)
    cmd(csr_pkg::OP_TABRD_M, 8'h30);
    rm(8'h30); `CHK("table low", x[7:0] ^ 8'ha5, got[7:0])
    rm(8'h08); `CHK("table high", x[15:8] + 8'h3c, got[7:0])
    bus(1'b0, 11'h200, 32'h0); `CHK("unmapped", 32'h0, got)
    tally_and_finish();
  end
endmodule

bind csr_core csr_core_chk u_csr_core_chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .TABLE_DATA(TABLE_DATA),
  .TABLE_ADDRESS(TABLE_ADDRESS), .PROG_COUNTER(PROG_COUNTER),
  .CORE_FLAGS(CORE_FLAGS), .DUMMY_CYCLE(DUMMY_CYCLE));
